/* File: rtl/rrm_pkg.sv */
// Constants and types shared by the ring node and its peer.
// Assumes a single 10 MHz clock shared by both ends of the ring link.
`default_nettype none

package rrm_pkg;

  // ------------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------------
  localparam int CLK_PERIOD_NS  = 100;
  localparam int RECONF_TIME_MS = 200;
  // Longest time, rounded down to whole cycles
  localparam int RECONF_CYC     = (RECONF_TIME_MS * 1000000) / CLK_PERIOD_NS;
  // three missed periods plus reconnection fit the budget
  localparam int DEF_TEST_PERIOD_CYC = RECONF_CYC / 10;
  localparam int DEF_MISS_LIMIT      = 3;

  // ------------------------------------------------------------------
  // Ring geometry and field widths
  // ------------------------------------------------------------------
  localparam int MAX_RING_NODES = 50;
  localparam int NUM_RING_PORTS = 2;
  localparam int DOMAIN_W       = 8;
  localparam int ID_W           = 8;
  localparam int PAYLOAD_W      = 8;

  localparam logic [DOMAIN_W-1:0] DEFAULT_DOMAIN = 8'h01;
  localparam logic                DEFAULT_SWAP   = 1'h0;
  localparam logic                DEFAULT_DIAG   = 1'h0;

  // ------------------------------------------------------------------
  // Diagnostic event positions
  // ------------------------------------------------------------------
  localparam int EV_LINK_LOSS = 0;
  localparam int EV_NO_SUPP   = 1;
  localparam int EV_NON_RING  = 2;
  localparam int EV_FOREIGN   = 3;
  localparam int EV_ROLE_CHG  = 4;
  localparam int NUM_EV       = 5;

  typedef enum logic [1:0] {
    ROLE_NONE     = 2'b00,
    ROLE_CLIENT   = 2'b01,
    ROLE_MANAGER  = 2'b10,
    ROLE_MGR_AUTO = 2'b11
  } rrm_role_t;

  localparam rrm_role_t DEFAULT_ROLE = ROLE_MGR_AUTO;

  typedef enum logic [1:0] {
    KIND_DATA  = 2'b00,
    KIND_TEST  = 2'b01,
    KIND_ALT   = 2'b10,
    KIND_PLAIN = 2'b11
  } rrm_kind_t;

  typedef enum logic {
    RS_CLOSED = 1'b0,
    RS_OPEN   = 1'b1
  } rrm_ring_t;

  typedef struct packed {
    rrm_kind_t             kind;
    logic [DOMAIN_W-1:0]   domain;
    logic [ID_W-1:0]       src_id;
    logic                  origin;
    logic [PAYLOAD_W-1:0]  payload;
  } rrm_frame_t;

endpackage : rrm_pkg

`default_nettype wire

/* File: rtl/rrm_ring_if.sv */
// Ring link between a node's two ring ports and the rest of the ring.
// Index 0 and 1 are the node's physical ports; one frame per cycle each.
`default_nettype none

interface rrm_ring_if;
  logic                 node_valid [2];
  rrm_pkg::rrm_frame_t  node_frame [2];
  logic                 peer_valid [2];
  rrm_pkg::rrm_frame_t  peer_frame [2];
  logic                 link_up    [2];
  logic                 autoneg    [2];

  modport node (
    output node_valid, node_frame, autoneg,
    input  peer_valid, peer_frame, link_up
  );

  modport peer (
    input  node_valid, node_frame, autoneg,
    output peer_valid, peer_frame, link_up
  );
endinterface : rrm_ring_if

`default_nettype wire

/* File: rtl/rrm_node.sv */
// Ring redundancy node: manager or client with two ring ports.
// Assumes the ring peer shares its clock; one frame per port per cycle.
//
// How it works
// - Active manager blocks forwarding while ring intact
// - Manager sends test frames on both ports
// - Missing test frames make manager join ports
// - Reconfiguration finishes within 0.2 seconds
// - At most 50 nodes share one ring
// - One manager per ring, others are clients
// - One shared domain per ring, one per node
// - Different rings use different domains
// - Settings survive restart; only configuration changes them
// - Fast startup only when node not in ring
// - Alternative redundancy method frames are never mixed in
// - Clients keep forwarding if manager fails
// - Default domain keeps default role and ports
// - Open ring before role change; configure first
// - Ring ports use automatic link negotiation
// - Factory settings start as auto-negotiated manager
// - Diagnostics raise events on ring faults
`default_nettype none

module rrm_node #(
  parameter int                        TEST_PERIOD_CYC = rrm_pkg::DEF_TEST_PERIOD_CYC,
  parameter int                        MISS_LIMIT      = rrm_pkg::DEF_MISS_LIMIT,
  // Arbitrary value, unique per node
  parameter logic [rrm_pkg::ID_W-1:0]  NODE_ID         = 8'h10
) (
  // Clock and reset
  input  wire logic                           clock,
  input  wire logic                           reset,
  // Ring link
  rrm_ring_if.node                            ring,
  // Stored settings
  input  wire logic                           nv_factory_reset,
  input  wire logic                           cfg_write,
  input  wire logic [rrm_pkg::DOMAIN_W-1:0]   cfg_domain,
  input  wire rrm_pkg::rrm_role_t             cfg_role,
  input  wire logic                           cfg_swap,
  input  wire logic                           cfg_diag_en,
  // Local traffic
  input  wire logic                           usr_tx_valid,
  input  wire logic [rrm_pkg::PAYLOAD_W-1:0]  usr_tx_payload,
  output logic                                usr_tx_done,
  output logic                                usr_rx_valid,
  output logic [rrm_pkg::PAYLOAD_W-1:0]       usr_rx_payload,
  // Status
  output rrm_pkg::rrm_role_t                  role_out,
  output logic [rrm_pkg::DOMAIN_W-1:0]        domain_out,
  output logic                                mgr_active,
  output logic                                ring_open,
  output logic                                fast_startup_ok,
  output logic [rrm_pkg::NUM_EV-1:0]          diag_event
);

  localparam int CNT_W  = $clog2(TEST_PERIOD_CYC + 1);
  localparam int MISS_W = $clog2(MISS_LIMIT + 1);
  localparam logic [CNT_W-1:0]  PERIOD_LAST = CNT_W'(TEST_PERIOD_CYC - 1);
  localparam logic [MISS_W-1:0] MISS_MAX    = MISS_W'(MISS_LIMIT);

  // ------------------------------------------------------------------
  // Stored settings
  // ------------------------------------------------------------------
  // No reset: these model non-volatile storage, so a restart keeps them.
  // The first power-up must pass through nv_factory_reset.
  logic [rrm_pkg::DOMAIN_W-1:0] domain_reg, domain_next;
  rrm_pkg::rrm_role_t           role_reg, role_next;
  logic                         swap_reg, swap_next;
  logic                         diag_reg, diag_next;

  always_comb
  begin
    domain_next = domain_reg;
    role_next   = role_reg;
    swap_next   = swap_reg;
    diag_next   = diag_reg;
    if (nv_factory_reset)
    begin
      domain_next = rrm_pkg::DEFAULT_DOMAIN;
      role_next   = rrm_pkg::DEFAULT_ROLE;
      swap_next   = rrm_pkg::DEFAULT_SWAP;
      diag_next   = rrm_pkg::DEFAULT_DIAG;
    end
    else if (cfg_write)
    begin
      domain_next = cfg_domain;
      diag_next   = cfg_diag_en;
      if (cfg_domain == rrm_pkg::DEFAULT_DOMAIN)
      begin
        role_next = rrm_pkg::DEFAULT_ROLE;
        swap_next = rrm_pkg::DEFAULT_SWAP;
      end
      else
      begin
        role_next = cfg_role;
        swap_next = cfg_swap;
      end
    end
  end

  always_ff @(posedge clock)
  begin
    domain_reg <= domain_next;
    role_reg   <= role_next;
    swap_reg   <= swap_next;
    diag_reg   <= diag_next;
  end

  // ------------------------------------------------------------------
  // Received frame classification
  // ------------------------------------------------------------------
  logic in_ring;
  logic own_test [2];
  logic foreign  [2];
  logic lower_mgr[2];
  logic own_seen;
  logic heard_lower;

  assign in_ring = (role_reg != rrm_pkg::ROLE_NONE);

  for (genvar p = 0; p < 2; p++)
  begin : g_class
    logic is_test;
    assign is_test     = ring.peer_valid[p] && (ring.peer_frame[p].kind == rrm_pkg::KIND_TEST);
    assign foreign[p]  = is_test && (ring.peer_frame[p].domain != domain_reg);
    assign own_test[p] = is_test && !foreign[p] && (ring.peer_frame[p].src_id == NODE_ID);
    assign lower_mgr[p] = is_test && !foreign[p] && (ring.peer_frame[p].src_id < NODE_ID);
  end

  assign own_seen    = own_test[0] || own_test[1];
  assign heard_lower = lower_mgr[0] || lower_mgr[1];

  // ------------------------------------------------------------------
  // Manager supervision
  // ------------------------------------------------------------------
  logic [CNT_W-1:0]    cnt_reg, cnt_next;
  logic [MISS_W-1:0]   miss_reg, miss_next;
  logic                seen_reg, seen_next;
  logic                passive_reg, passive_next;
  rrm_pkg::rrm_ring_t  state_reg, state_next;
  logic                tick;
  logic                active_now;

  assign tick       = (cnt_reg == PERIOD_LAST);
  // auto role yields to a lower id
  assign active_now = (role_reg == rrm_pkg::ROLE_MANAGER) ||
                      ((role_reg == rrm_pkg::ROLE_MGR_AUTO) && !passive_reg);

  always_comb
  begin
    cnt_next     = tick ? '0 : cnt_reg + 1'b1;
    seen_next    = seen_reg || own_seen;
    miss_next    = miss_reg;
    passive_next = passive_reg;
    state_next   = state_reg;
    if (heard_lower)
      passive_next = 1'b1;
    else if (miss_reg == MISS_MAX)
      passive_next = 1'b0;
    if (tick)
    begin
      // A test frame arriving on the tick still counts as seen
      seen_next = 1'b0;
      if (seen_reg || own_seen)
        miss_next = '0;
      else if (miss_reg != MISS_MAX)
        miss_next = miss_reg + 1'b1;
    end
    case (state_reg)
      rrm_pkg::RS_CLOSED:
        if (active_now && (miss_reg == MISS_MAX))
          state_next = rrm_pkg::RS_OPEN;
      rrm_pkg::RS_OPEN:
        if (!active_now || own_seen)
          state_next = rrm_pkg::RS_CLOSED;
      default:
        state_next = rrm_pkg::RS_CLOSED;
    endcase
  end

  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      cnt_reg     <= '0;
      miss_reg    <= '0;
      seen_reg    <= 1'b0;
      passive_reg <= 1'b0;
      state_reg   <= rrm_pkg::RS_CLOSED;
    end
    else
    begin
      cnt_reg     <= cnt_next;
      miss_reg    <= miss_next;
      seen_reg    <= seen_next;
      passive_reg <= passive_next;
      state_reg   <= state_next;
    end
  end

  // ------------------------------------------------------------------
  // Port forwarding and transmit
  // ------------------------------------------------------------------
  // blocked on an active manager while intact
  logic fwd_en;
  logic usr_port;
  logic usr_sent;
  logic tx_valid_next [2];
  rrm_pkg::rrm_frame_t tx_frame_next [2];
  logic tx_valid_reg  [2];
  rrm_pkg::rrm_frame_t tx_frame_reg  [2];

  assign fwd_en   = !active_now || (state_reg == rrm_pkg::RS_OPEN);
  assign usr_port = swap_reg;
  assign usr_sent = usr_tx_valid && in_ring && !tx_valid_next[usr_port];

  for (genvar p = 0; p < 2; p++)
  begin : g_tx
    localparam int Q = 1 - p;
    logic pass;
    // only own-method data and test frames pass
    assign pass = ring.peer_valid[Q] && in_ring && fwd_en && !foreign[Q] && !own_test[Q] &&
                  ((ring.peer_frame[Q].kind == rrm_pkg::KIND_DATA) ||
                   (ring.peer_frame[Q].kind == rrm_pkg::KIND_TEST));
    always_comb
    begin
      tx_valid_next[p] = 1'b0;
      tx_frame_next[p] = ring.peer_frame[Q];
      if (tick && active_now && in_ring)
      begin
        tx_valid_next[p]        = 1'b1;
        tx_frame_next[p].kind   = rrm_pkg::KIND_TEST;
        tx_frame_next[p].domain = domain_reg;
        tx_frame_next[p].src_id = NODE_ID;
        tx_frame_next[p].origin = 1'(p) ^ swap_reg;
        tx_frame_next[p].payload = '0;
      end
      else if (pass)
        tx_valid_next[p] = 1'b1;
    end
    always_ff @(posedge clock)
    begin
      if (reset)
      begin
        tx_valid_reg[p] <= 1'b0;
        tx_frame_reg[p] <= '0;
      end
      else if (usr_sent && (1'(p) == usr_port))
      begin
        tx_valid_reg[p] <= 1'b1;
        tx_frame_reg[p] <= '{rrm_pkg::KIND_DATA, domain_reg, NODE_ID, 1'b0, usr_tx_payload};
      end
      else
      begin
        tx_valid_reg[p] <= tx_valid_next[p];
        tx_frame_reg[p] <= tx_frame_next[p];
      end
    end
    assign ring.node_valid[p] = tx_valid_reg[p];
    assign ring.node_frame[p] = tx_frame_reg[p];
    assign ring.autoneg[p] = 1'b1;
  end

  // ------------------------------------------------------------------
  // Local delivery, diagnostics and status
  // ------------------------------------------------------------------
  logic [rrm_pkg::NUM_EV-1:0] ev_next;
  logic                       link_d [2];
  logic                       rx_hit0, rx_hit1;

  assign rx_hit0 = ring.peer_valid[0] && ring.peer_frame[0].kind == rrm_pkg::KIND_DATA &&
                   ring.peer_frame[0].domain == domain_reg;
  assign rx_hit1 = ring.peer_valid[1] && ring.peer_frame[1].kind == rrm_pkg::KIND_DATA &&
                   ring.peer_frame[1].domain == domain_reg;

  always_comb
  begin
    ev_next = '0;
    for (int p = 0; p < 2; p++)
    begin
      ev_next[rrm_pkg::EV_LINK_LOSS] |= link_d[p] && !ring.link_up[p];
      ev_next[rrm_pkg::EV_NO_SUPP]   |= ring.peer_valid[p] &&
                                        ring.peer_frame[p].kind == rrm_pkg::KIND_ALT;
      ev_next[rrm_pkg::EV_NON_RING]  |= ring.peer_valid[p] &&
                                        ring.peer_frame[p].kind == rrm_pkg::KIND_PLAIN;
      ev_next[rrm_pkg::EV_FOREIGN]   |= foreign[p];
    end
    ev_next[rrm_pkg::EV_ROLE_CHG] = (active_now != mgr_active);
    if (!diag_reg || !in_ring)
      ev_next = '0;
  end

  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      link_d          <= '{1'b0, 1'b0};
      diag_event      <= '0;
      usr_tx_done     <= 1'b0;
      usr_rx_valid    <= 1'b0;
      usr_rx_payload  <= '0;
      role_out        <= rrm_pkg::ROLE_NONE;
      domain_out      <= '0;
      mgr_active      <= 1'b0;
      ring_open       <= 1'b0;
      fast_startup_ok <= 1'b0;
    end
    else
    begin
      link_d          <= ring.link_up;
      diag_event      <= ev_next;
      usr_tx_done     <= usr_sent;
      usr_rx_valid    <= in_ring && (rx_hit0 || rx_hit1);
      usr_rx_payload  <= rx_hit0 ? ring.peer_frame[0].payload : ring.peer_frame[1].payload;
      role_out        <= role_reg;
      domain_out      <= domain_reg;
      mgr_active      <= active_now && in_ring;
      ring_open       <= (state_reg == rrm_pkg::RS_OPEN);
      fast_startup_ok <= !in_ring;
    end
  end

endmodule : rrm_node

`default_nettype wire

/* File: rtl/rrm_peer.sv */
// Rest of the ring as one client chain joining the node's two ports.
// Assumes the node shares its clock; one frame per port per cycle.
`default_nettype none

module rrm_peer (
  // Clock and reset
  input  wire logic                           clock,
  input  wire logic                           reset,
  // Ring link
  rrm_ring_if.peer                            ring,
  // Ring control
  input  wire logic [rrm_pkg::DOMAIN_W-1:0]   peer_domain,
  input  wire logic                           break_ring,
  // Frame injection from a far client
  input  wire logic                           inj_valid,
  input  wire logic                           inj_port,
  input  wire rrm_pkg::rrm_frame_t            inj_frame,
  // Observation
  output logic                                obs_valid,
  output rrm_pkg::rrm_frame_t                 obs_frame,
  output logic                                autoneg_err,
  output logic                                two_managers
);

  logic                      first_seen_reg;
  logic [rrm_pkg::ID_W-1:0]  first_id_reg;
  logic                      obs_next;
  rrm_pkg::rrm_frame_t       obs_frame_next;

  // ------------------------------------------------------------------
  // Forwarding through the client chain
  // ------------------------------------------------------------------
  for (genvar p = 0; p < 2; p++)
  begin : g_fwd
    localparam int Q = 1 - p;
    logic                keep;
    logic                valid_reg;
    rrm_pkg::rrm_frame_t frame_reg;
    // clients drop other domains; clients forward while unbroken
    assign keep = ring.node_valid[Q] && !break_ring &&
                  (ring.node_frame[Q].domain == peer_domain);
    always_ff @(posedge clock)
    begin
      if (reset)
      begin
        valid_reg <= 1'b0;
        frame_reg <= '0;
      end
      else if (inj_valid && (1'(p) == inj_port))
      begin
        valid_reg <= 1'b1;
        frame_reg <= inj_frame;
      end
      else
      begin
        valid_reg <= keep;
        frame_reg <= ring.node_frame[Q];
      end
    end
    assign ring.peer_valid[p] = valid_reg;
    assign ring.peer_frame[p] = frame_reg;
  end

  // ------------------------------------------------------------------
  // Link state and checks
  // ------------------------------------------------------------------
  always_comb
  begin
    obs_next       = ring.node_valid[0] || ring.node_valid[1];
    obs_frame_next = ring.node_valid[0] ? ring.node_frame[0] : ring.node_frame[1];
  end

  logic link_reg;

  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      link_reg       <= 1'b0;
      obs_valid      <= 1'b0;
      obs_frame      <= '0;
      autoneg_err    <= 1'b0;
      two_managers   <= 1'b0;
      first_seen_reg <= 1'b0;
      first_id_reg   <= '0;
    end
    else
    begin
      link_reg    <= !break_ring;
      obs_valid   <= obs_next;
      obs_frame   <= obs_frame_next;
      autoneg_err <= autoneg_err || !ring.autoneg[0] || !ring.autoneg[1];
      // a second test source means two managers
      if (obs_next && obs_frame_next.kind == rrm_pkg::KIND_TEST)
      begin
        first_seen_reg <= 1'b1;
        if (!first_seen_reg)
          first_id_reg <= obs_frame_next.src_id;
        else if (obs_frame_next.src_id != first_id_reg)
          two_managers <= 1'b1;
      end
    end
  end

  assign ring.link_up[0] = link_reg;
  assign ring.link_up[1] = link_reg;

endmodule : rrm_peer

`default_nettype wire

/* File: verification/rrm_ring_asserts.sv */
// Checker on the ring link between node and peer.
// Assumes both ends sample on the rising clock edge.
`default_nettype none

module rrm_ring_asserts #(
  parameter int                       TEST_PERIOD_CYC = 20,
  parameter int                       MISS_LIMIT      = 3,
  parameter logic [rrm_pkg::ID_W-1:0] NODE_ID         = 8'h10
) (
  // Clock and reset
  input wire logic                clock,
  input wire logic                reset,
  // Ring link
  input wire logic                node_valid [2],
  input wire rrm_pkg::rrm_frame_t node_frame [2],
  input wire logic                peer_valid [2],
  input wire rrm_pkg::rrm_frame_t peer_frame [2],
  input wire logic                link_up    [2],
  input wire logic                autoneg    [2]
);
  timeunit 1ns;
  timeprecision 1ns;
  localparam int OPEN_CYC = (MISS_LIMIT + 1) * TEST_PERIOD_CYC + 2;

  // ----------------------------------------------------------------
  // Helper logic
  // ----------------------------------------------------------------
  logic own0;
  logic own1;
  logic back;
  int   quiet_reg;
  function automatic logic is_own(logic v, rrm_pkg::rrm_frame_t f);
    return v && f.kind == rrm_pkg::KIND_TEST && f.src_id == NODE_ID;
  endfunction : is_own
  assign own0 = is_own(node_valid[0], node_frame[0]);
  assign own1 = is_own(node_valid[1], node_frame[1]);
  assign back = is_own(peer_valid[0], peer_frame[0]) || is_own(peer_valid[1], peer_frame[1]);
  // Saturates: a long open period never wraps into the intact window
  always_ff @(posedge clock)
  begin
    quiet_reg <= (reset || back) ? 0 : (quiet_reg < 1000 ? quiet_reg + 1 : quiet_reg);
  end

  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (reset);

  property p_autoneg;
    autoneg[0] && autoneg[1];
  endproperty
  a_autoneg: assert property (p_autoneg) else $error("ring port on fixed link settings");
  property p_quiet_reset;
    $fell(reset) |-> !node_valid[0] && !node_valid[1];
  endproperty
  a_quiet_reset: assert property (p_quiet_reset) else $error("frame sent out of reset");
  property p_both_tests;
    own0 || own1 |-> own0 && own1;
  endproperty
  a_both_tests: assert property (p_both_tests) else $error("test frame on one port only");
  property p_spacing;
    own0 |=> !own0 [*8];
  endproperty
  a_spacing: assert property (p_spacing) else $error("test frames too close");
  property p_block;
    quiet_reg >= 2 && quiet_reg < TEST_PERIOD_CYC && peer_valid[0]
      && peer_frame[0].kind == rrm_pkg::KIND_DATA
      |=> !(node_valid[1] && node_frame[1] == $past(peer_frame[0]));
  endproperty
  a_block: assert property (p_block) else $error("intact ring forwarded a frame");
  property p_forward;
    quiet_reg > OPEN_CYC && peer_valid[0] && peer_frame[0].kind == rrm_pkg::KIND_DATA
      |=> node_valid[1] && (node_frame[1] == $past(peer_frame[0])
      || node_frame[1].kind == rrm_pkg::KIND_TEST);
  endproperty
  a_forward: assert property (p_forward) else $error("broken ring not bridged");
  property p_return;
    own0 && link_up[0] |=> !link_up[0]
      || (peer_valid[1] && peer_frame[1] == $past(node_frame[0]));
  endproperty
  a_return: assert property (p_return) else $error("ring lost a test frame");
  property p_alt;
    peer_valid[0] && peer_frame[0].kind == rrm_pkg::KIND_ALT
      |=> !(node_valid[1] && node_frame[1].kind == rrm_pkg::KIND_ALT);
  endproperty
  a_alt: assert property (p_alt) else $error("alternative method frame passed");

  c_back: cover property (back);
  c_forward: cover property (quiet_reg > OPEN_CYC && node_valid[1]);
  c_alt: cover property (peer_valid[0] && peer_frame[0].kind == rrm_pkg::KIND_ALT);
endmodule : rrm_ring_asserts

`default_nettype wire

/* File: verification/ring_redundancy_manager_bench.sv */
// Self-checking bench: node and peer on one ring link.
// Assumes rtl/ package and interface compile first.
`default_nettype none

module ring_redundancy_manager_bench;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int P = 20;
  localparam int M = 3;
  logic clock, reset, nv_factory_reset, cfg_write, cfg_swap, cfg_diag_en;
  logic [7:0] cfg_domain, usr_tx_payload, usr_rx_payload, domain_out, peer_domain;
  logic usr_tx_valid, usr_tx_done, usr_rx_valid, mgr_active, ring_open, fast_startup_ok;
  logic break_ring, inj_valid, inj_port, obs_valid, autoneg_err, two_managers;
  logic [4:0] diag_event, diag_seen;
  rrm_pkg::rrm_role_t  cfg_role, role_out;
  rrm_pkg::rrm_frame_t inj_frame, obs_frame;
  logic [7:0] exp_q[$];
  int miscompares, check_count, n;

  // ----------------------------------------------------------------
  // Design and checker
  // ----------------------------------------------------------------
  rrm_ring_if rrm_ring_if_inst();
  rrm_node #(.TEST_PERIOD_CYC(P), .MISS_LIMIT(M), .NODE_ID(8'h10)) rrm_node_inst (
    .clock, .reset, .ring(rrm_ring_if_inst), .nv_factory_reset, .cfg_write, .cfg_domain,
    .cfg_role, .cfg_swap, .cfg_diag_en, .usr_tx_valid, .usr_tx_payload, .usr_tx_done,
    .usr_rx_valid, .usr_rx_payload, .role_out, .domain_out, .mgr_active, .ring_open,
    .fast_startup_ok, .diag_event);
  rrm_peer rrm_peer_inst (
    .clock, .reset, .ring(rrm_ring_if_inst), .peer_domain, .break_ring, .inj_valid,
    .inj_port, .inj_frame, .obs_valid, .obs_frame, .autoneg_err, .two_managers);
  rrm_ring_asserts #(.TEST_PERIOD_CYC(P), .MISS_LIMIT(M), .NODE_ID(8'h10)) chk (
    .clock(clock), .reset(reset), .node_valid(rrm_ring_if_inst.node_valid),
    .node_frame(rrm_ring_if_inst.node_frame), .peer_valid(rrm_ring_if_inst.peer_valid),
    .peer_frame(rrm_ring_if_inst.peer_frame), .link_up(rrm_ring_if_inst.link_up),
    .autoneg(rrm_ring_if_inst.autoneg));

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  always #50 clock = ~clock;
  always @(posedge clock) diag_seen <= diag_seen | diag_event;

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : tally_and_finish

  task automatic check(input string nm, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e)
    begin
      miscompares++;
      $display("MISMATCH %s expected %0h seen %0h", nm, e, g);
    end
  endtask : check

  task automatic wait_lvl(ref logic s, input logic v, input int lim, output int k);
    k = 0;
    while (s !== v && k < lim)
    begin
      @(negedge clock);
      k++;
    end
    check("wait", v, s);
    if (s !== v) tally_and_finish();
  endtask : wait_lvl

  task automatic cfg(input logic [7:0] d, input rrm_pkg::rrm_role_t r);
    @(negedge clock);
    cfg_write = 1'b1;
    cfg_domain = d;
    cfg_role = r;
    cfg_diag_en = 1'b1;
    @(negedge clock);
    cfg_write = 1'b0;
    repeat (3) @(negedge clock);
  endtask : cfg

  task automatic send(input logic p, input rrm_pkg::rrm_kind_t k, input logic [7:0] d,
                      input logic e);
    logic [7:0] pl;
    pl = 8'($urandom);
    @(negedge clock);
    inj_valid = 1'b1;
    inj_port = p;
    inj_frame = '{k, d, 8'h33, 1'b0, pl};
    if (e) exp_q.push_back(pl);
    @(negedge clock);
    inj_valid = 1'b0;
    repeat (3) @(negedge clock);
  endtask : send

  // Scoreboard: each delivery is the oldest note
  always @(negedge clock)
    if (usr_rx_valid === 1'b1)
    begin
      if (exp_q.size() == 0) check("rx unexpected", 0, 1);
      else check("rx payload", exp_q.pop_front(), usr_rx_payload);
    end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    void'($urandom(32'hb157332e));
    {clock, reset, nv_factory_reset} = 3'h3;
    {cfg_write, cfg_swap, cfg_diag_en, usr_tx_valid, break_ring, inj_valid, inj_port} = '0;
    {cfg_domain, usr_tx_payload, inj_frame, cfg_role, diag_seen} = '0;
    peer_domain = 8'h01;
    repeat (3) @(negedge clock);
    {reset, nv_factory_reset} = 2'h0;
    repeat (2) @(negedge clock);
    check("factory role", rrm_pkg::ROLE_MGR_AUTO, role_out);
    check("factory domain", 8'h01, domain_out);
    $display("test defaults done");
    break_ring = 1'b1;
    cfg(8'h01, rrm_pkg::ROLE_CLIENT);
    check("default keeps role", rrm_pkg::ROLE_MGR_AUTO, role_out);
    cfg(8'h22, rrm_pkg::ROLE_MANAGER);
    peer_domain = 8'h22;
    check("new role", rrm_pkg::ROLE_MANAGER, role_out);
    check("new domain", 8'h22, domain_out);
    break_ring = 1'b0;
    wait_lvl(ring_open, 1'b0, 3 * P, n);
    repeat (2 * P) @(negedge clock);
    check("manager active", 1, mgr_active);
    check("one manager", 0, two_managers);
    check("no fast startup", 0, fast_startup_ok);
    send(1'b0, rrm_pkg::KIND_DATA, 8'h22, 1'b1);
    usr_tx_valid = 1'b1;
    usr_tx_payload = 8'($urandom);
    exp_q.push_back(usr_tx_payload);
    wait_lvl(usr_tx_done, 1'b1, P, n);
    usr_tx_valid = 1'b0;
    @(negedge clock);
    check("tx frame", usr_tx_payload, obs_frame.payload);
    $display("test intact ring done");
    for (int i = 1; i <= 3; i++)
    begin
      diag_seen = '0;
      send(1'b0, i == 3 ? rrm_pkg::KIND_TEST : rrm_pkg::rrm_kind_t'(i + 1),
           i == 3 ? 8'h5A : 8'h22, 1'b0);
      check("diag event", 1, diag_seen[i]);
    end
    $display("test refused kinds done");
    diag_seen = '0;
    break_ring = 1'b1;
    wait_lvl(ring_open, 1'b1, (M + 1) * P + 3, n);
    check("not too early", 1, n >= (M - 1) * P);
    check("link loss event", 1, diag_seen[rrm_pkg::EV_LINK_LOSS]);
    repeat (P + 4) @(negedge clock);
    send(1'b0, rrm_pkg::KIND_DATA, 8'h22, 1'b1);
    break_ring = 1'b0;
    wait_lvl(ring_open, 1'b0, 3 * P, n);
    $display("test break and heal done");
    reset = 1'b1;
    @(negedge clock);
    reset = 1'b0;
    repeat (2) @(negedge clock);
    check("kept role", rrm_pkg::ROLE_MANAGER, role_out);
    check("kept domain", 8'h22, domain_out);
    $display("test restart done");
    break_ring = 1'b1;
    cfg(8'h22, rrm_pkg::ROLE_NONE);
    break_ring = 1'b0;
    check("fast startup", 1, fast_startup_ok);
    send(1'b1, rrm_pkg::KIND_DATA, 8'h22, 1'b0);
    check("autoneg", 0, autoneg_err);
    check("rx drained", 0, exp_q.size());
    $display("test not in ring done");
    tally_and_finish();
  end
endmodule : ring_redundancy_manager_bench

`default_nettype wire
